// >>> rtl/usart_defs.vh
`ifndef USART_DEFS_VH
`define USART_DEFS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_W            8
`define DATA_W            8
`define RX_STAT_CTRL_ADDR 8'h18
`define RX_BUF_ADDR       8'h1a
`define IRQ_STATUS_ADDR   8'h20
`define IRQ_CLEAR_ADDR    8'h21
`define IRQ_ENABLE_ADDR   8'h22
`define PORT_C_DIR_ADDR   8'h87
`define TX_STAT_CTRL_ADDR 8'h98

// ----------------------------------------------------------------
// Receive status and control fields
// ----------------------------------------------------------------
`define SERIAL_PORT_ENABLE_BIT          7
`define RX9_BIT           6
`define SINGLE_RECEIVE_ENABLE_BIT          5
`define CONTINUOUS_RECEIVE_ENABLE_BIT          4
`define FRAMING_ERROR_FLAG_BIT          2
`define OVERRUN_ERROR_FLAG_BIT          1
`define RX9D_BIT          0

// ----------------------------------------------------------------
// Transmit status and control fields
// ----------------------------------------------------------------
`define CSRC_BIT          7
`define SYNC_BIT          4
`define TX_WR_MASK        8'hf5
`define TX_RESET          8'h02

// ----------------------------------------------------------------
// Pin direction, interrupt events, reset values
// ----------------------------------------------------------------
`define DIR_CLK_BIT       6
`define DIR_DATA_BIT      7
`define DIR_RESET         8'h00
`define CTRL_RESET        8'h00
`define EV_W              3
`define EV_RX_DONE        0
`define EV_FRAMING_ERROR_FLAG           1
`define EV_OVERRUN_ERROR_FLAG           2
`define EV_RESET          3'h0
`define LAST_BIT_8        4'h7
`define LAST_BIT_9        4'h8

`endif

// >>> rtl/usart_rx_engine.v
`timescale 1ns/1ps
`include "usart_defs.vh"

module usart_rx_engine (
  input  wire       i_mclk,
  input  wire       i_rst_n,
  input  wire       i_enable,
  input  wire       i_sync,
  input  wire       i_master,
  input  wire       i_nine,
  input  wire       i_rx_on,
  input  wire       i_bit_tick,
  input  wire       i_data_in,
  input  wire       i_clk_in,
  output reg        o_done,
  output reg  [8:0] o_data,
  output reg        o_frame_err,
  output reg        o_clk_out,
  output reg        o_clk_oe
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_DATA = 2'b01;
  localparam [1:0] ST_STOP = 2'b10;

  reg [1:0] state_reg;
  reg [3:0] cnt_reg;
  reg [8:0] shift_reg;
  reg       clk_prev_reg;

  wire [3:0] last_bit   = i_nine ? `LAST_BIT_9 : `LAST_BIT_8;
  // Master samples as its own clock rises; slave on the peer's rising edge
  wire       sync_edge  = i_master ? (i_bit_tick & ~o_clk_out) : (i_clk_in & ~clk_prev_reg);
  wire       sample     = i_sync ? sync_edge : i_bit_tick;
  wire [8:0] shifted    = {i_data_in, shift_reg[8:1]};
  wire [8:0] aligned    = i_nine ? shifted : {1'b0, shifted[8:1]};

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (!i_rst_n || !i_enable) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= 4'h0;
      shift_reg    <= 9'h000;
      clk_prev_reg <= 1'b0;
      o_done       <= 1'b0;
      o_data       <= 9'h000;
      o_frame_err  <= 1'b0;
      o_clk_out    <= 1'b0;
      o_clk_oe     <= 1'b0;
    end else begin
      clk_prev_reg <= i_clk_in;
      o_done       <= 1'b0;
      o_clk_oe     <= i_sync & i_master;
      if (i_sync && i_master && state_reg == ST_DATA && i_bit_tick)
        o_clk_out <= ~o_clk_out;
      else if (state_reg == ST_IDLE)
        o_clk_out <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 4'h0;
          // sync receive free-running; async waits for a low start bit on a tick
          // Hold off one cycle after a character so a self-clearing
          // single receive cannot restart the clock before it drops
          if (i_rx_on && !o_done && (i_sync || (i_bit_tick && !i_data_in)))
            state_reg <= ST_DATA;
        end
        ST_DATA: begin
          if (i_sync && !i_rx_on) begin
            state_reg <= ST_IDLE;
          end else if (sample) begin
            shift_reg <= shifted;
            cnt_reg   <= cnt_reg + 4'h1;
            if (cnt_reg == last_bit) begin
              if (i_sync) begin
                state_reg   <= ST_IDLE;
                o_done      <= 1'b1;
                o_data      <= aligned;
                o_frame_err <= 1'b0;
              end else begin
                state_reg <= ST_STOP;
              end
            end
          end
        end
        ST_STOP: begin
          if (i_bit_tick) begin
            state_reg   <= ST_IDLE;
            o_done      <= 1'b1;
            o_data      <= i_nine ? shift_reg : {1'b0, shift_reg[8:1]};
            o_frame_err <= ~i_data_in;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // usart_rx_engine

// >>> rtl/usart_control_status.v
`timescale 1ns/1ps
`include "usart_defs.vh"

// How it works
// - The port runs asynchronously with receive independent of transmit, so both directions work at once.
// - The port also runs synchronously half duplex, as clock master or slave, chosen by configuration.
// - The receiver takes nine-bit characters when the nine-bit select is one, else eight-bit ones.
// - The framing error flag is set by a bad stop bit and refreshed when the next character is loaded.
// - The overrun error flag is set when a character is lost and cleared by clearing continuous receive.

module usart_control_status (
  input  wire                i_mclk,
  input  wire                i_rst_n,
  input  wire [`ADDR_W-1:0]  i_addr,
  input  wire [`DATA_W-1:0]  i_wdata,
  input  wire                i_wr,
  input  wire                i_rd,
  output reg  [`DATA_W-1:0]  o_rdata,
  output reg                 o_irq,
  input  wire                i_bit_tick,
  input  wire                i_transmit_clock_pin_in,
  output wire                o_transmit_clock_pin_out,
  output wire                o_transmit_clock_pin_oe,
  input  wire                i_receive_data_pin_in,
  output reg                 o_receive_data_pin_out,
  output reg                 o_receive_data_pin_oe
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  reg [`DATA_W-1:0] rx_ctrl_reg;
  reg [`DATA_W-1:0] tx_ctrl_reg;
  reg [`DATA_W-1:0] dir_reg;
  reg [8:0]         buf_reg;
  reg               buf_full_reg;
  reg               framing_error_flag_reg;
  reg               overrun_error_flag_reg;
  reg [`EV_W-1:0]   ev_status_reg;
  reg [`EV_W-1:0]   ev_enable_reg;

  reg [`DATA_W-1:0] rx_ctrl_next;
  reg [`EV_W-1:0]   ev_status_next;
  reg [`EV_W-1:0]   events;

  wire       rx_done;
  wire [8:0] rx_data;
  wire       rx_framing_error_flag;

  wire wr_rx_ctrl = i_wr & hit(i_addr, `RX_STAT_CTRL_ADDR);
  wire rd_buf     = i_rd & hit(i_addr, `RX_BUF_ADDR);

  wire serial_port_enable   = rx_ctrl_reg[`SERIAL_PORT_ENABLE_BIT];
  wire continuous_receive_enable   = rx_ctrl_reg[`CONTINUOUS_RECEIVE_ENABLE_BIT];
  wire single_receive_enable   = rx_ctrl_reg[`SINGLE_RECEIVE_ENABLE_BIT];
  wire sync   = tx_ctrl_reg[`SYNC_BIT];
  wire master = tx_ctrl_reg[`CSRC_BIT];

  wire port_on = serial_port_enable & dir_reg[`DIR_CLK_BIT] & dir_reg[`DIR_DATA_BIT];

  wire rx_on = sync ? (master ? (continuous_receive_enable | single_receive_enable) : continuous_receive_enable) : continuous_receive_enable;

  // Overrun holds reception off so the unread character is kept intact
  // receiver halts on overrun
  wire rx_run = rx_on & ~overrun_error_flag_reg;

  wire lost = rx_done & buf_full_reg & ~rd_buf;

  // ----------------------------------------------------------------
  // Receiver engine
  // ----------------------------------------------------------------
  usart_rx_engine u_rx (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_enable    (port_on),
    .i_sync      (sync),
    .i_master    (master),
    .i_nine      (rx_ctrl_reg[`RX9_BIT]),
    .i_rx_on     (rx_run),
    .i_bit_tick  (i_bit_tick),
    .i_data_in   (i_receive_data_pin_in),
    .i_clk_in    (i_transmit_clock_pin_in),
    .o_done      (rx_done),
    .o_data      (rx_data),
    .o_frame_err (rx_framing_error_flag),
    .o_clk_out   (o_transmit_clock_pin_out),
    .o_clk_oe    (o_transmit_clock_pin_oe)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always @* begin
    rx_ctrl_next = rx_ctrl_reg;
    if (wr_rx_ctrl)
      rx_ctrl_next = i_wdata;
    if (rx_done && sync && master && !continuous_receive_enable)
      rx_ctrl_next[`SINGLE_RECEIVE_ENABLE_BIT] = 1'b0;
    events                = {`EV_W{1'b0}};
    events[`EV_RX_DONE]   = rx_done & ~lost;
    events[`EV_FRAMING_ERROR_FLAG]      = rx_done & ~lost & rx_framing_error_flag;
    events[`EV_OVERRUN_ERROR_FLAG]      = lost;
    ev_status_next = ev_status_reg;
    if (i_wr && hit(i_addr, `IRQ_CLEAR_ADDR))
      ev_status_next = ev_status_reg & ~i_wdata[`EV_W-1:0];
    // Set beats a same-cycle clear
    ev_status_next = ev_status_next | events;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rx_ctrl_reg   <= `CTRL_RESET;
      tx_ctrl_reg   <= `TX_RESET;
      dir_reg       <= `DIR_RESET;
      ev_enable_reg <= `EV_RESET;
    end else begin
      rx_ctrl_reg <= rx_ctrl_next;
      // Transmit shift status is forced to empty; no transmitter here
      if (i_wr && hit(i_addr, `TX_STAT_CTRL_ADDR))
        tx_ctrl_reg <= (i_wdata & `TX_WR_MASK) | `TX_RESET;
      if (i_wr && hit(i_addr, `PORT_C_DIR_ADDR))
        dir_reg <= i_wdata;
      if (i_wr && hit(i_addr, `IRQ_ENABLE_ADDR))
        ev_enable_reg <= i_wdata[`EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer and error flags
  // ----------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      buf_reg      <= 9'h000;
      buf_full_reg <= 1'b0;
      framing_error_flag_reg     <= 1'b0;
      overrun_error_flag_reg     <= 1'b0;
    end else begin
      if (rx_done && !lost) begin
        buf_reg      <= rx_data;
        buf_full_reg <= 1'b1;
        framing_error_flag_reg     <= rx_framing_error_flag;
      end else if (rd_buf) begin
        buf_full_reg <= 1'b0;
      end
      if (lost)
        overrun_error_flag_reg <= 1'b1;
      else if (!rx_ctrl_next[`CONTINUOUS_RECEIVE_ENABLE_BIT])
        overrun_error_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and line
  // ----------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ev_status_reg <= `EV_RESET;
      o_irq         <= 1'b0;
    end else begin
      ev_status_reg <= ev_status_next;
      // Built from the next status so the line changes on the same edge as the flag
      o_irq         <= |(ev_status_next & ev_enable_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read data and pins
  // ----------------------------------------------------------------
  function [`DATA_W-1:0] rx_view;
    input [`DATA_W-1:0] ctrl;
    input               framing_error_flag;
    input               overrun_error_flag;
    input               ninth;
    begin
      rx_view            = ctrl & `TX_WR_MASK;
      rx_view[`FRAMING_ERROR_FLAG_BIT] = framing_error_flag;
      rx_view[`OVERRUN_ERROR_FLAG_BIT] = overrun_error_flag;
      rx_view[`RX9D_BIT] = ninth;
    end
  endfunction

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rdata                <= {`DATA_W{1'b0}};
      o_receive_data_pin_out <= 1'b0;
      o_receive_data_pin_oe  <= 1'b0;
    end else begin
      // Transmit datapath lives elsewhere; data pin is only sampled here
      o_receive_data_pin_out <= 1'b0;
      o_receive_data_pin_oe  <= 1'b0;
      o_rdata <= {`DATA_W{1'b0}};
      if (i_rd) begin
        case (i_addr)
          `RX_STAT_CTRL_ADDR: o_rdata <= rx_view(rx_ctrl_reg, framing_error_flag_reg, overrun_error_flag_reg, buf_reg[8]);
          `RX_BUF_ADDR:       o_rdata <= buf_reg[`DATA_W-1:0];
          `TX_STAT_CTRL_ADDR: o_rdata <= tx_ctrl_reg;
          `PORT_C_DIR_ADDR:   o_rdata <= dir_reg;
          `IRQ_STATUS_ADDR:   o_rdata <= {{(`DATA_W-`EV_W){1'b0}}, ev_status_reg};
          `IRQ_ENABLE_ADDR:   o_rdata <= {{(`DATA_W-`EV_W){1'b0}}, ev_enable_reg};
          default:            o_rdata <= {`DATA_W{1'b0}};
        endcase
      end
    end
  end

endmodule // usart_control_status

// >>> tb/usart_control_status_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module usart_control_status_chk (
  input wire       i_mclk,
  input wire       i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  input wire       o_irq,
  input wire       o_transmit_clock_pin_oe,
  input wire       o_receive_data_pin_oe
);
  logic [7:0] rxm, txm, dirm, ien;
  wire        mst = rxm[7] & txm[7] & txm[4] & (dirm[7:6] == 2'b11);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Bus-side copies, so no view inside the block is needed
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      {rxm, txm, dirm, ien} <= 32'h0;
    end else if (i_wr) begin
      if (i_addr == 8'h18) rxm <= i_wdata;
      if (i_addr == 8'h98) txm <= i_wdata;
      if (i_addr == 8'h87) dirm <= i_wdata;
      if (i_addr == 8'h22) ien <= i_wdata;
    end
  end
  AST_TX_READ: assert property (i_rd && i_addr == 8'h98 |=>
    o_rdata == ((txm & 8'hf5) | 8'h02)) else $error("tx control readback wrong");
  AST_RX_READ: assert property (i_rd && i_addr == 8'h18 |=>
    o_rdata[7:6] == rxm[7:6] && o_rdata[4] == rxm[4] && !o_rdata[3])
    else $error("rx control readback wrong");
  AST_CLK_OE: assert property (o_transmit_clock_pin_oe |-> mst || $past(mst))
    else $error("clock pin driven without sync master setup");
  AST_CLK_OE_ON: assert property (mst && $past(mst) |=> o_transmit_clock_pin_oe)
    else $error("clock pin not driven in sync master");
  AST_DATA_OE_OFF: assert property (!o_receive_data_pin_oe)
    else $error("data pin driven by receive side");
  AST_OVERRUN_ERROR_FLAG_CLEAR: assert property (i_rd && i_addr == 8'h18 && !rxm[4] && !$past(rxm[4])
    |=> !o_rdata[1]) else $error("overrun kept with continuous receive off");
  AST_IRQ_MASK: assert property (ien == 8'h00 && $past(ien) == 8'h00 |-> !o_irq)
    else $error("interrupt while all sources masked");
  AST_STATUS_LAYOUT: assert property (i_rd && i_addr == 8'h20 |=> o_rdata[7:3] == 5'h00)
    else $error("event status upper bits set");
endmodule // usart_control_status_chk

bind usart_control_status usart_control_status_chk u_chk (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
  .o_transmit_clock_pin_oe(o_transmit_clock_pin_oe),
  .o_receive_data_pin_oe(o_receive_data_pin_oe)
);

// >>> tb/usart_peer.sv
`timescale 1ns/1ps
// ----------------------------------------
// Serial peer, sends one frame per request
// ----------------------------------------
module usart_peer (
  input  wire        i_mclk,
  input  wire        i_tick,
  input  wire        i_go,
  input  wire [10:0] i_frame,
  output logic       o_line,
  output logic       o_busy
);
  logic [10:0] sh;
  logic [3:0]  n;
  initial begin
    o_line = 1'b1;
    o_busy = 1'b0;
  end
  // frame out, stop bit may be bad; idle line is high
  always @(posedge i_mclk) begin
    if (i_go) begin
      o_line <= 1'b0;
      sh     <= i_frame;
      n      <= 4'hb;
      o_busy <= 1'b1;
    end else if (i_tick && o_busy) begin
      o_line <= sh[0];
      sh     <= {1'b1, sh[10:1]};
      n      <= n - 4'h1;
      o_busy <= (n != 4'h1);
    end
  end
endmodule // usart_peer

// >>> tb/usart_control_status_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module usart_control_status_tb;
  logic        i_mclk, i_rst_n, i_wr, i_rd, i_bit_tick, go, busy, line, o_irq, oe;
  logic [7:0]  i_addr, i_wdata, o_rdata, d;
  logic [10:0] fr;
  logic        sck, sck_d, sclk, sdat;
  logic [7:0]  v;
  int          nrise;
  logic [1:0]  tc;
  int          errors, checked, i, k;
  int          exp_q[$];
  usart_control_status dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_bit_tick(i_bit_tick),
    .i_transmit_clock_pin_in(sclk), .o_transmit_clock_pin_out(sck),
    .o_transmit_clock_pin_oe(oe), .i_receive_data_pin_in(line & sdat),
    .o_receive_data_pin_out(), .o_receive_data_pin_oe());
  usart_peer peer (.i_mclk(i_mclk), .i_tick(i_bit_tick), .i_go(go), .i_frame(fr),
    .o_line(line), .o_busy(busy));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    tc         <= tc + 2'h1;
    i_bit_tick <= (tc == 2'h3);
    sck_d      <= sck;
    if (sck && !sck_d) nrise <= nrise + 1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic ck(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rd(a);
    `CHK(d & m, e)
  endtask
  task automatic send(input logic [8:0] v, input logic nine, input logic bad);
    @(posedge i_mclk);
    fr <= nine ? {1'b1, ~bad, v} : {2'b11, ~bad, v[7:0]};
    go <= 1'b1;
    @(posedge i_mclk);
    go <= 1'b0;
    for (i = 0; i < 100; i++) begin
      @(posedge i_mclk);
      if (busy === 1'b0) break;
    end
    if (i == 100) begin errors++; summarize(); end
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    summarize();
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_bit_tick, go, i_addr, i_wdata, fr, tc, sclk} = 0;
    sdat = 1'b1;
    nrise = 0;
    errors = 0;
    checked = 0;
    k = $urandom(66740);
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    ck(8'h18, 8'h00, 8'hfe);
    ck(8'h98, 8'h02, 8'hff);
    ck(8'h87, 8'h00, 8'hff);
    ck(8'h55, 8'h00, 8'hff);
    $display("done reset");
    wr(8'h87, 8'hc0);
    wr(8'h22, 8'h07);
    wr(8'h18, 8'h90);
    for (k = 0; k < 4; k++) begin
      exp_q.push_back($urandom & 8'hff);
      send(9'(exp_q[0]), 1'b0, k == 1);
      ck(8'h18, (k == 1) ? 8'h94 : 8'h90, 8'hfe);
      ck(8'h20, (k == 1) ? 8'h03 : 8'h01, 8'hff);
      `CHK(o_irq, 1'b1)
      ck(8'h1a, 8'(exp_q.pop_front()), 8'hff);
      wr(8'h21, 8'h07);
      repeat (2) @(posedge i_mclk);
      `CHK(o_irq, 1'b0)
    end
    wr(8'h18, 8'hd0);
    for (k = 0; k < 2; k++) begin
      exp_q.push_back(($urandom & 8'hff) | (k << 8));
      send(9'(exp_q[0]), 1'b1, 1'b0);
      ck(8'h18, 8'hd0 | 8'(exp_q[0] >> 8), 8'hff);
      ck(8'h1a, 8'(exp_q.pop_front()), 8'hff);
    end
    $display("done receive");
    wr(8'h22, 8'h00);
    wr(8'h21, 8'h07);
    wr(8'h18, 8'h90);
    send(9'h0a5, 1'b0, 1'b0);
    `CHK(o_irq, 1'b0)
    ck(8'h20, 8'h01, 8'hff);
    ck(8'h1a, 8'ha5, 8'hff);
    wr(8'h21, 8'h07);
    wr(8'h22, 8'h07);
    $display("done mask");
    // Second char lands on a full buffer and is lost
    send(9'h03c, 1'b0, 1'b0);
    send(9'h0c3, 1'b0, 1'b0);
    ck(8'h18, 8'h92, 8'hfe);
    ck(8'h20, 8'h05, 8'hff);
    ck(8'h1a, 8'h3c, 8'hff);
    wr(8'h21, 8'h07);
    send(9'h05a, 1'b0, 1'b0);
    ck(8'h20, 8'h00, 8'hff);
    wr(8'h18, 8'h80);
    ck(8'h18, 8'h80, 8'hfe);
    wr(8'h18, 8'h90);
    send(9'h077, 1'b0, 1'b0);
    ck(8'h1a, 8'h77, 8'hff);
    $display("done overrun");
    wr(8'h98, 8'h90);
    wr(8'h18, 8'ha0);
    repeat (3) @(posedge i_mclk);
    `CHK(oe, 1'b1)
    for (k = 0; k < 60; k++) begin
      rd(8'h18);
      if (d[5] === 1'b0) break;
    end
    `CHK(d & 8'hf0, 8'h80)
    `CHK(nrise, 8)
    ck(8'h1a, 8'hff, 8'hff);
    ck(8'h98, 8'h92, 8'hff);
    wr(8'h98, 8'h00);
    repeat (3) @(posedge i_mclk);
    `CHK(oe, 1'b0)
    $display("done sync");
    // Slave: peer clock on the clock pin, data LSB first
    wr(8'h98, 8'h10);
    wr(8'h18, 8'h90);
    v = $urandom & 8'hff;
    for (k = 0; k < 8; k++) begin
      sdat <= v[k];
      repeat (2) @(posedge i_mclk);
      sclk <= 1'b1;
      repeat (2) @(posedge i_mclk);
      sclk <= 1'b0;
    end
    sdat <= 1'b1;
    repeat (4) @(posedge i_mclk);
    `CHK(oe, 1'b0)
    ck(8'h1a, v, 8'hff);
    $display("done slave");
    summarize();
  end
endmodule // usart_control_status_tb
